//--- inc/smbus_cfg_consts.vh
// Constants for the bus clock configuration block
`ifndef SMBUS_CFG_CONSTS_VH
`define SMBUS_CFG_CONSTS_VH

// Register address and reset value
`define CFG_REG_ADDR        8'hC1
`define CFG_REG_RESET       8'h00

// Field positions in the configuration register
`define BIT_ENABLE          7
`define BIT_INHIBIT         6
`define BIT_BUSY            5
`define BIT_EXTEND          4
`define BIT_TOE             3
`define BIT_FTE             2
`define SRC_MSB             1
`define SRC_LSB             0

// Bit rate source codes
`define SRC_T0              2'h0
`define SRC_T1              2'h1
`define SRC_T2H             2'h2
`define SRC_T2L             2'h3

// Timing counts in system clocks
`define SETUP_EXT_CYC       4'hB
`define SETUP_NORM_CYC      4'h1
`define HOLD_EXT_CYC        4'hC
`define HOLD_NORM_CYC       4'h3

// Timing counts in source overflow periods
`define LOW_TICKS           2'h1
`define HIGH_TICKS          2'h2
`define FREE_TICKS          4'hA

`endif

//--- design/line_sync.v
// Three-stage synchroniser with agreement filter for one bus line
`timescale 1ns/1ns
module line_sync
(
    ref_clk,
    resetn,
    pin_in,
    level
);
    input  wire ref_clk;
    input  wire resetn;
    input  wire pin_in;
    output wire level;

    reg         s1_ff;
    reg         s2_ff;
    reg         s3_ff;
    reg         level_ff;

    // Idle bus level is high; the level moves once stages two and three agree
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_ff    <= 1'b1;
            s2_ff    <= 1'b1;
            s3_ff    <= 1'b1;
            level_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                level_ff <= s3_ff;
        end
    end

    assign level = level_ff;
endmodule

//--- design/smbus_config_control.v
// Configuration, busy, timeout and master clock pacing for the serial bus
//
// What this block does
// RULE_01 - Bit 7 enables the interface, which then watches both bus lines.
// RULE_02 - Bit 6 suppresses slave event interrupts but not master ones.
// RULE_03 - Bit 5 is a read-only busy flag set while a transfer is running.
// RULE_04 - Busy clears on a sensed STOP or on a free-bus timeout.
// RULE_05 - Bit 4 selects normal or extended data setup and hold times.
// RULE_06 - With bit 3 set the timeout timer reloads while the clock is high.
// RULE_07 - In split mode only the timer high byte is held in reload.
// RULE_08 - Software sets the timeout timer to 25 ms and resets the bus.
// RULE_09 - With bit 2 set the bus is free after both lines stay high >10 ticks.
// RULE_10 - Bits 1:0 pick timer 0, timer 1, timer 2 high or low overflow.
// RULE_11 - The source is used only as master or with free timeout enabled.
// RULE_12 - Master clock low and high phases last at least one tick each.
// RULE_13 - Uncontended master rate is tick rate over 5, high three ticks and low two.
// RULE_14 - Extended timing gives 11 clocks setup and 12 hold, else 3 hold.
// RULE_15 - While disabled the lines are released and no events occur.
// RULE_16 - Writable fields and the busy flag reset to zero.
`timescale 1ns/1ns
`include "smbus_cfg_consts.vh"
module smbus_config_control
(
    ref_clk,
    resetn,
    sfr_addr,
    sfr_wr,
    sfr_wdata,
    sfr_rdata,
    scl_in,
    sda_in,
    scl_out,
    scl_oe,
    sda_out,
    sda_oe,
    t0_overflow,
    t1_overflow,
    t2h_overflow,
    t2l_overflow,
    timer_split_mode,
    master_clk_run,
    master_sda_bit,
    slave_event,
    master_event,
    slave_irq,
    master_irq,
    timer_reload,
    timer_high_reload,
    bus_start,
    bus_stop,
    free_timeout,
    bit_tick
);
    input  wire       ref_clk;
    input  wire       resetn;
    input  wire [7:0] sfr_addr;
    input  wire       sfr_wr;
    input  wire [7:0] sfr_wdata;
    output wire [7:0] sfr_rdata;
    input  wire       scl_in;
    input  wire       sda_in;
    output wire       scl_out;
    output wire       scl_oe;
    output wire       sda_out;
    output wire       sda_oe;
    input  wire       t0_overflow;
    input  wire       t1_overflow;
    input  wire       t2h_overflow;
    input  wire       t2l_overflow;
    input  wire       timer_split_mode;
    input  wire       master_clk_run;
    input  wire       master_sda_bit;
    input  wire       slave_event;
    input  wire       master_event;
    output wire       slave_irq;
    output wire       master_irq;
    output wire       timer_reload;
    output wire       timer_high_reload;
    output wire       bus_start;
    output wire       bus_stop;
    output wire       free_timeout;
    output wire       bit_tick;

    // Master clock states
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_LOW  = 3'h2;
    localparam [2:0] ST_HIGH = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Line synchronisers
    wire        scl_s;
    wire        sda_s;

    line_sync u_scl_sync
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin_in  (scl_in),
        .level   (scl_s)
    );

    line_sync u_sda_sync
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin_in  (sda_in),
        .level   (sda_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg         en_ff;
    reg         inh_ff;
    reg         busy_ff;
    reg         ext_ff;
    reg         toe_ff;
    reg         fte_ff;
    reg  [1:0]  src_ff;
    reg  [7:0]  rdata_ff;
    reg         inh_eff_ff;
    reg         sda_prev_ff;
    reg  [3:0]  idle_cnt_ff;
    reg  [2:0]  state_ff;
    reg  [1:0]  tick_cnt_ff;
    reg  [3:0]  hold_cnt_ff;
    reg  [3:0]  setup_cnt_ff;
    reg         hold_done_ff;
    reg         scl_oe_ff;
    reg         sda_oe_ff;
    reg         slave_irq_ff;
    reg         master_irq_ff;
    reg         reload_ff;
    reg         high_reload_ff;
    reg         start_ff;
    reg         stop_ff;
    reg         free_ff;
    reg         tick_ff;

    // Selected overflow source
    function src_pick;
        input [1:0] sel;
        input       a;
        input       b;
        input       c;
        input       d;
        begin
            if (sel == `SRC_T0)
                src_pick = a;
            else if (sel == `SRC_T1)
                src_pick = b;
            else if (sel == `SRC_T2H)
                src_pick = c;
            else
                src_pick = d;
        end
    endfunction

    wire cfg_hit   = sfr_wr && (sfr_addr == `CFG_REG_ADDR);
    wire master_on = (state_ff != ST_IDLE);
    wire raw_tick  = src_pick(src_ff, t0_overflow, t1_overflow,
                              t2h_overflow, t2l_overflow);              // [RULE_10]
    wire tick      = en_ff && raw_tick && (master_on || fte_ff);       // [RULE_11]
    wire start_det = en_ff && scl_s && sda_prev_ff && !sda_s;          // [RULE_01]
    wire stop_det  = en_ff && scl_s && !sda_prev_ff && sda_s;
    wire both_high = scl_s && sda_s;
    wire free_det  = fte_ff && both_high && tick
                     && (idle_cnt_ff == `FREE_TICKS);                   // [RULE_09]
    wire [3:0] hold_cyc  = ext_ff ? `HOLD_EXT_CYC : `HOLD_NORM_CYC;    // [RULE_14]
    wire [3:0] setup_cyc = ext_ff ? `SETUP_EXT_CYC : `SETUP_NORM_CYC;  // [RULE_05]
    wire setup_ok  = hold_done_ff && (setup_cnt_ff >= setup_cyc);

    ////////////////////////////////////////////////////////////////////////
    // Configuration register; busy bit is not writable
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_ff  <= 1'b0;                                             // [RULE_16]
            inh_ff <= 1'b0;
            ext_ff <= 1'b0;
            toe_ff <= 1'b0;
            fte_ff <= 1'b0;
            src_ff <= 2'h0;
        end
        else if (cfg_hit)
        begin
            en_ff  <= sfr_wdata[`BIT_ENABLE];
            inh_ff <= sfr_wdata[`BIT_INHIBIT];
            ext_ff <= sfr_wdata[`BIT_EXTEND];
            toe_ff <= sfr_wdata[`BIT_TOE];
            fte_ff <= sfr_wdata[`BIT_FTE];
            src_ff <= sfr_wdata[`SRC_MSB:`SRC_LSB];
        end
    end

    // Read data, zero for any other address
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rdata_ff <= `CFG_REG_RESET;
        else if (sfr_addr == `CFG_REG_ADDR)
            rdata_ff <= {en_ff, inh_ff, busy_ff, ext_ff,
                         toe_ff, fte_ff, src_ff};
        else
            rdata_ff <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy flag, line events and free-bus detection
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_ff     <= 1'b0;                                        // [RULE_16]
            sda_prev_ff <= 1'b1;
            idle_cnt_ff <= 4'h0;
            inh_eff_ff  <= 1'b0;
            start_ff    <= 1'b0;
            stop_ff     <= 1'b0;
            free_ff     <= 1'b0;
            tick_ff     <= 1'b0;
        end
        else
        begin
            sda_prev_ff <= sda_s;
            start_ff    <= start_det;
            stop_ff     <= stop_det;
            free_ff     <= free_det;
            tick_ff     <= tick;
            // Busy set wins over a STOP or free-bus clear in the same cycle
            if (!en_ff)
                busy_ff <= 1'b0;                                        // [RULE_15]
            else if (start_det || master_on)
                busy_ff <= 1'b1;                                        // [RULE_03]
            else if (stop_det || free_det)
                busy_ff <= 1'b0;                                        // [RULE_04]
            // Count ticks with both lines high; saturate after firing
            if (!fte_ff || !en_ff || !both_high)
                idle_cnt_ff <= 4'h0;
            else if (tick && (idle_cnt_ff <= `FREE_TICKS))
                idle_cnt_ff <= idle_cnt_ff + 4'h1;                      // [RULE_09]
            // Inhibit takes hold at the next START
            if (!en_ff || start_det)
                inh_eff_ff <= inh_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts and timeout timer control
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slave_irq_ff   <= 1'b0;
            master_irq_ff  <= 1'b0;
            reload_ff      <= 1'b0;
            high_reload_ff <= 1'b0;
        end
        else
        begin
            slave_irq_ff   <= en_ff && slave_event && !inh_eff_ff;     // [RULE_02]
            master_irq_ff  <= en_ff && master_event;                    // [RULE_15]
            reload_ff      <= en_ff && toe_ff && scl_s
                              && !timer_split_mode;                     // [RULE_06]
            high_reload_ff <= en_ff && toe_ff && scl_s;                 // [RULE_07]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master clock generator with data hold and setup spacing
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff     <= ST_IDLE;
            tick_cnt_ff  <= 2'h0;
            hold_cnt_ff  <= 4'h0;
            setup_cnt_ff <= 4'h0;
            hold_done_ff <= 1'b0;
            scl_oe_ff    <= 1'b0;
            sda_oe_ff    <= 1'b0;
        end
        else if (!en_ff)
        begin
            state_ff     <= ST_IDLE;                                    // [RULE_15]
            scl_oe_ff    <= 1'b0;
            sda_oe_ff    <= 1'b0;
            tick_cnt_ff  <= 2'h0;
            hold_done_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (master_clk_run)
                    begin
                        state_ff     <= ST_LOW;
                        scl_oe_ff    <= 1'b1;
                        tick_cnt_ff  <= 2'h0;
                        hold_cnt_ff  <= 4'h0;
                        hold_done_ff <= 1'b0;
                    end
                end
                ST_LOW:
                begin
                    // Data may move only after the hold count
                    if (!hold_done_ff)
                    begin
                        hold_cnt_ff <= hold_cnt_ff + 4'h1;
                        if (hold_cnt_ff + 4'h1 >= hold_cyc)             // [RULE_14]
                        begin
                            hold_done_ff <= 1'b1;
                            sda_oe_ff    <= !master_sda_bit;
                            setup_cnt_ff <= 4'h0;
                        end
                    end
                    else if (setup_cnt_ff != 4'hF)
                        setup_cnt_ff <= setup_cnt_ff + 4'h1;
                    if (tick && tick_cnt_ff != 2'h3)
                        tick_cnt_ff <= tick_cnt_ff + 2'h1;
                    // Release after one full tick period and data setup
                    if ((tick_cnt_ff >= `LOW_TICKS) && tick
                        && setup_ok)                                    // [RULE_12]
                    begin
                        state_ff    <= ST_HIGH;
                        scl_oe_ff   <= 1'b0;
                        tick_cnt_ff <= 2'h0;
                    end
                end
                ST_HIGH:
                begin
                    // High time counts only once the line is seen high
                    if (!scl_s)
                        tick_cnt_ff <= 2'h0;
                    else if (tick && (tick_cnt_ff >= `HIGH_TICKS))      // [RULE_13]
                    begin
                        tick_cnt_ff  <= 2'h0;
                        hold_cnt_ff  <= 4'h0;
                        hold_done_ff <= 1'b0;
                        if (master_clk_run)
                        begin
                            state_ff  <= ST_LOW;
                            scl_oe_ff <= 1'b1;
                        end
                        else
                        begin
                            state_ff  <= ST_IDLE;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                    else if (tick)
                        tick_cnt_ff <= tick_cnt_ff + 2'h1;
                end
                default:
                begin
                    state_ff  <= ST_IDLE;
                    scl_oe_ff <= 1'b0;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; open-drain lines only ever pull low
    assign sfr_rdata         = rdata_ff;
    assign scl_out           = 1'b0;
    assign sda_out           = 1'b0;
    assign scl_oe            = scl_oe_ff;
    assign sda_oe            = sda_oe_ff;
    assign slave_irq         = slave_irq_ff;
    assign master_irq        = master_irq_ff;
    assign timer_reload      = reload_ff;
    assign timer_high_reload = high_reload_ff;
    assign bus_start         = start_ff;
    assign bus_stop          = stop_ff;
    assign free_timeout      = free_ff;
    assign bit_tick          = tick_ff;
endmodule

//--- verification/smbus_config_control_asserts.sv
// Port assertions for the bus clock configuration block
`timescale 1ns/1ns
`include "smbus_cfg_consts.vh"
module smbus_config_control_asserts
(
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       sda_out,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       t0_overflow,
    input wire logic       t1_overflow,
    input wire logic       t2h_overflow,
    input wire logic       t2l_overflow,
    input wire logic       timer_split_mode,
    input wire logic       slave_event,
    input wire logic       master_event,
    input wire logic       slave_irq,
    input wire logic       master_irq,
    input wire logic       timer_reload,
    input wire logic       timer_high_reload,
    input wire logic       bus_start,
    input wire logic       bus_stop,
    input wire logic       bit_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Disable write and the quiet state that must follow it
    sequence s_disable;
        sfr_wr && sfr_addr == `CFG_REG_ADDR && !sfr_wdata[`BIT_ENABLE];
    endsequence
    sequence s_quiet;
        !scl_oe && !sda_oe && !timer_high_reload && !bus_start;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    property p_out_const;
        scl_out == 1'b0 && sda_out == 1'b0;
    endproperty
    property p_rdata;
        $past(sfr_addr) != `CFG_REG_ADDR |-> sfr_rdata == 8'h00;
    endproperty
    property p_master_irq;
        master_irq |-> $past(master_event);
    endproperty
    property p_slave_irq;
        slave_irq |-> $past(slave_event);
    endproperty
    property p_split;
        $past(timer_split_mode) |-> !timer_reload;
    endproperty
    property p_reload_pair;
        timer_reload |-> timer_high_reload;
    endproperty
    property p_scl_low;
        (!scl_in) [*8] |-> !timer_high_reload;
    endproperty
    property p_tick;
        bit_tick |-> $past(t0_overflow | t1_overflow | t2h_overflow
                           | t2l_overflow);
    endproperty
    property p_stop_pulse;
        bus_stop |=> !bus_stop && !bus_start;
    endproperty
    property p_quiet;
        s_disable |=> ##2 s_quiet;
    endproperty

    ////////////////////////////////////////////////////////////////////////
    a_out_const: assert property (p_out_const)
        else $error("bus outputs not held low");
    a_rdata: assert property (p_rdata)
        else $error("read data without register select");
    a_master_irq: assert property (p_master_irq)
        else $error("master irq without master event");
    a_slave_irq: assert property (p_slave_irq)
        else $error("slave irq without slave event");
    a_split: assert property (p_split)
        else $error("full reload in split mode");
    a_reload_pair: assert property (p_reload_pair)
        else $error("full reload without high byte reload");
    a_scl_low: assert property (p_scl_low)
        else $error("reload held while clock line low");
    a_tick: assert property (p_tick)
        else $error("bit tick without overflow");
    a_stop_pulse: assert property (p_stop_pulse)
        else $error("stop pulse longer than one cycle");
    a_quiet: assert property (p_quiet)
        else $error("activity after disable");
endmodule

//--- verification/smbus_peer.sv
// Model of another device sharing the two open-drain bus lines
`timescale 1ns/1ns
module smbus_peer
(
    input  wire logic ref_clk,
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output wire logic scl,
    output wire logic sda
);
    reg scl_pull = 1'b0;
    reg sda_pull = 1'b0;

    // Pull-ups: a line is low when any party pulls it
    assign scl = ~(scl_oe | scl_pull);
    assign sda = ~(sda_oe | sda_pull);

    // Change the pulls just after an edge, then hold them for a while
    task drive(input c, input d);
    begin
        @(posedge ref_clk);
        scl_pull <= c;
        sda_pull <= d;
        repeat (12) @(posedge ref_clk);
        #1;
    end
    endtask
endmodule

//--- verification/smbus_config_control_bench.sv
// Self-checking bench for the bus clock configuration block
`timescale 1ns/1ns
`include "smbus_cfg_consts.vh"
module smbus_config_control_bench;
    localparam [7:0] ADDR = `CFG_REG_ADDR;
    reg        ref_clk = 1'b0;
    reg        resetn = 1'b0;
    reg  [7:0] sfr_addr = 8'h00;
    reg        sfr_wr = 1'b0;
    reg  [7:0] sfr_wdata = 8'h00;
    reg  [3:0] ov = 4'h0;
    reg        split = 1'b0;
    reg        run = 1'b0;
    reg        m_bit = 1'b1;
    reg        m_ev = 1'b0;
    reg        s_ev = 1'b0;
    reg        clr = 1'b1;
    reg  [7:0] cnt [0:5];
    wire [7:0] sfr_rdata;
    wire       scl, sda, scl_oe, sda_oe, t_rl, t_hrl;
    wire       s_irq, m_irq, b_start, b_stop, f_to, tick_o;
    wire [5:0] pulse = {s_irq, m_irq, tick_o, f_to, b_stop, b_start};
    integer    n_mismatch = 0;
    integer    checks_done = 0;
    integer    cycles = 0;
    integer    k, i, s;

    always #25 ref_clk = ~ref_clk;

    smbus_config_control dut
    (
        .ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe(scl_oe),
        .sda_out(), .sda_oe(sda_oe), .t0_overflow(ov[0]),
        .t1_overflow(ov[1]), .t2h_overflow(ov[2]), .t2l_overflow(ov[3]),
        .timer_split_mode(split), .master_clk_run(run),
        .master_sda_bit(m_bit), .slave_event(s_ev), .master_event(m_ev),
        .slave_irq(s_irq), .master_irq(m_irq), .timer_reload(t_rl),
        .timer_high_reload(t_hrl), .bus_start(b_start),
        .bus_stop(b_stop), .free_timeout(f_to), .bit_tick(tick_o)
    );

    smbus_peer peer
    (
        .ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl(scl), .sda(sda)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters and the hang limit
    always @(posedge ref_clk)
    begin
        for (k = 0; k < 6; k = k + 1)
            cnt[k] <= clr ? 8'h00 : cnt[k] + {7'h00, pulse[k]};
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    end
    endtask

    task wr(input [7:0] d);
    begin
        @(posedge ref_clk);
        sfr_addr <= ADDR;
        sfr_wr <= 1'b1;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    end
    endtask

    task rd(input [7:0] a, input [7:0] exp);
    begin
        @(posedge ref_clk);
        sfr_addr <= a;
        @(posedge ref_clk);
        #1;
        chk(sfr_rdata, exp);
    end
    endtask

    task settle(input integer n);
    begin
        repeat (n) @(posedge ref_clk);
        #1;
    end
    endtask

    // Clear the pulse counters
    task zero;
    begin
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    end
    endtask

    task tick(input integer n);
    begin
        @(posedge ref_clk);
        ov <= 4'h1 << n;
        @(posedge ref_clk);
        ov <= 4'h0;
    end
    endtask

    task pulse_ev;
    begin
        @(posedge ref_clk);
        m_ev <= 1'b1;
        s_ev <= 1'b1;
        @(posedge ref_clk);
        m_ev <= 1'b0;
        s_ev <= 1'b0;
        settle(2);
    end
    endtask

    task done_test(input [95:0] name);
        $display("test %0s done", name);
    endtask

    task finish_test;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(ADDR, 8'h00);
        rd(8'hC0, 8'h00);
        wr(8'hFF);
        rd(ADDR, 8'hDF);
        done_test("register");
        for (s = 0; s < 5; s = s + 1)
        begin
            wr(s < 4 ? {6'h21, s[1:0]} : 8'h80);
            zero;
            for (i = 0; i < 4; i = i + 1)
                tick(i);
            settle(2);
            chk(cnt[3], s < 4 ? 8'h01 : 8'h00);
        end
        done_test("source");
        wr(8'h80);
        zero;
        peer.drive(1'b0, 1'b1);
        chk(cnt[0], 8'h01);
        rd(ADDR, 8'hA0);
        wr(8'h80);
        rd(ADDR, 8'hA0);
        peer.drive(1'b0, 1'b0);
        chk(cnt[1], 8'h01);
        rd(ADDR, 8'h80);
        done_test("busy");
        wr(8'h84);
        peer.drive(1'b0, 1'b1);
        peer.drive(1'b1, 1'b1);
        peer.drive(1'b1, 1'b0);
        peer.drive(1'b0, 1'b0);
        zero;
        repeat (10) tick(0);
        settle(3);
        chk(cnt[2], 8'h00);
        rd(ADDR, 8'hA4);
        tick(0);
        settle(3);
        chk(cnt[2], 8'h01);
        rd(ADDR, 8'h84);
        done_test("free");
        wr(8'h80);
        zero;
        pulse_ev;
        chk(cnt[4], 8'h01);
        chk(cnt[5], 8'h01);
        wr(8'hC0);
        peer.drive(1'b0, 1'b1);
        zero;
        pulse_ev;
        chk(cnt[4], 8'h01);
        chk(cnt[5], 8'h00);
        peer.drive(1'b0, 1'b0);
        done_test("inhibit");
        // Timer pacing is software's job; only the reload levels are seen
        wr(8'h88);
        settle(8);
        chk({6'h00, t_rl, t_hrl}, 8'h03);
        @(posedge ref_clk) split <= 1'b1;
        settle(2);
        chk({6'h00, t_rl, t_hrl}, 8'h01);
        peer.drive(1'b1, 1'b0);
        chk({6'h00, t_rl, t_hrl}, 8'h00);
        peer.drive(1'b0, 1'b0);
        @(posedge ref_clk) split <= 1'b0;
        done_test("timeout");
        wr(8'h00);
        zero;
        peer.drive(1'b0, 1'b1);
        chk(cnt[0], 8'h00);
        rd(ADDR, 8'h00);
        peer.drive(1'b0, 1'b0);
        done_test("disable");
        wr(8'h80);
        @(posedge ref_clk)
        begin
            run <= 1'b1;
            m_bit <= 1'b0;
        end
        settle(2);
        chk({7'h00, scl_oe}, 8'h01);
        settle(20);
        chk({7'h00, scl_oe}, 8'h01);
        chk({7'h00, sda_oe}, 8'h01);
        // Low phase ends on the second tick, high phase on the third
        tick(0);
        settle(2);
        chk({7'h00, scl_oe}, 8'h01);
        tick(0);
        settle(2);
        chk({7'h00, scl_oe}, 8'h00);
        settle(6);
        tick(0);
        tick(0);
        settle(2);
        chk({7'h00, scl_oe}, 8'h00);
        tick(0);
        settle(2);
        chk({7'h00, scl_oe}, 8'h01);
        wr(8'h00);
        settle(4);
        chk({7'h00, scl_oe}, 8'h00);
        chk({7'h00, sda_oe}, 8'h00);
        @(posedge ref_clk)
        begin
            run <= 1'b0;
            m_bit <= 1'b1;
        end
        done_test("master");
        finish_test;
    end
endmodule

// Attach the port checker to every instance of the block
bind smbus_config_control smbus_config_control_asserts u_chk
(
    .ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .scl_in(scl_in), .scl_out(scl_out), .sda_out(sda_out),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .t0_overflow(t0_overflow),
    .t1_overflow(t1_overflow), .t2h_overflow(t2h_overflow),
    .t2l_overflow(t2l_overflow), .timer_split_mode(timer_split_mode),
    .slave_event(slave_event), .master_event(master_event),
    .slave_irq(slave_irq), .master_irq(master_irq),
    .timer_reload(timer_reload), .timer_high_reload(timer_high_reload),
    .bus_start(bus_start), .bus_stop(bus_stop), .bit_tick(bit_tick)
);
